// ===== rst_pwr_pkg.sv
// constants and types for the reset, watchdog and power-save block
`default_nettype none
package rst_pwr_pkg;
  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [3:0]  CTRL_OFF       = 4'h0;
  localparam logic [3:0]  WDT_OFF        = 4'h4;
  localparam logic [15:0] CTRL_RESET     = 16'h0003;
  localparam logic [15:0] CTRL_WR_MASK   = 16'h1f20;
  // -------------------------------------------------------------------
  // field positions of reset_control_reg
  // -------------------------------------------------------------------
  localparam int TRAP_BIT    = 15;
  localparam int ILLOP_BIT   = 14;
  localparam int REFOK_BIT   = 13;
  localparam int LV_EN_BIT   = 12;
  localparam int LV_THR_LSB  = 8;
  localparam int PIN_RST_BIT = 7;
  localparam int SOFT_RST_BIT = 6;
  localparam int DOG_SW_EN_BIT = 5;
  localparam int DOG_TMO_BIT = 4;
  localparam int SLEEP_BIT   = 3;
  localparam int IDLE_BIT    = 2;
  localparam int BOR_BIT     = 1;
  localparam int POR_BIT     = 0;
  // -------------------------------------------------------------------
  // restart vectors and oscillator families
  // -------------------------------------------------------------------
  localparam logic [23:0] RESET_VECTOR   = 24'h000000;
  localparam logic [23:0] CLKFAIL_VECTOR = 24'h000004;
  localparam logic [23:0] PC_STEP        = 24'h000002;
  localparam logic [1:0]  OSC_FAM_LP     = 2'h0;
  localparam logic [1:0]  OSC_FAM_FRC    = 2'h1;
  localparam logic [1:0]  OSC_FAM_LOW_POWER_RC_CLOCK   = 2'h2;
  localparam logic [1:0]  OSC_FAM_PRI    = 2'h3;
  localparam int          OSC_EXT_BIT    = 3;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          PWR_ON_US      = 10;
  localparam int          PWR_ON_CYCLES  =
    (PWR_ON_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // -------------------------------------------------------------------
  // power state, one-hot
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    PM_RUN   = 4'h1,
    PM_IDLE  = 4'h2,
    PM_SLEEP = 4'h4,
    PM_WAKE  = 4'h8
  } pm_state_t;
endpackage : rst_pwr_pkg
`default_nettype wire

// ===== reset_status_watchdog_sleep.sv
// reset cause flags, watchdog, low-voltage control and sleep sequencing
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
module reset_status_watchdog_sleep #(
  parameter logic [15:0] WDT_TERMINAL = 16'h0fff,
  parameter int unsigned PWRT_CYCLES  = 0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        por_event,
  input  wire logic        brown_out_reset,
  input  wire logic        external_reset_pin,
  input  wire logic        soft_reset_event,
  input  wire logic        trap_conflict_event,
  input  wire logic        illegal_op_event,
  input  wire logic        clock_fail_event,
  input  wire logic        irq_wake,
  input  wire logic [23:0] irq_vector,
  input  wire logic [23:0] pc_current,
  input  wire logic        power_save_instr,
  input  wire logic        power_save_sleep,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        low_power_rc_clock_tick,
  input  wire logic        watchdog_fuse_enable,
  input  wire logic [1:0]  osc_family_fuse,
  input  wire logic [3:0]  primary_osc_mode_fuse,
  input  wire logic [1:0]  current_osc_select,
  input  wire logic        clock_switch_enable,
  input  wire logic        lp_keep_in_sleep,
  input  wire logic        pll_used,
  input  wire logic        pll_lock,
  input  wire logic        osc_startup_done,
  input  wire logic        reference_ready,
  input  wire logic        voltage_below,
  output var  logic        restart_valid,
  output var  logic [23:0] restart_pc,
  output var  logic        cpu_clock_enable,
  output var  logic        periph_clock_enable,
  output var  logic        osc_run,
  output var  logic        fscm_enable,
  output var  logic        low_power_rc_clock_run,
  output var  logic        lvd_enable,
  output var  logic [3:0]  low_voltage_threshold,
  output var  logic        low_voltage_event,
  output var  logic [1:0]  wake_osc
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]           ctl;
    rst_pwr_pkg::pm_state_t mode;
    logic [15:0]           wdt_cnt;
    logic [31:0]           delay;
    logic                  need_osc;
    logic [23:0]           pend_pc;
    logic                  rst_valid;
    logic [23:0]           rst_pc;
    logic                  waitreq;
    logic [31:0]           rdata;
    logic                  cpu_en;
    logic                  per_en;
    logic                  osc_en;
    logic                  fscm_en;
    logic                  low_power_rc_clock_en;
    logic                  lv_event;
    logic [1:0]            osc_sel;
  } state_t;

  localparam state_t RESET_STATE = '{
    ctl:      rst_pwr_pkg::CTRL_RESET,
    mode:     rst_pwr_pkg::PM_RUN,
    wdt_cnt:  16'h0000,
    delay:    32'h00000000,
    need_osc: 1'b0,
    pend_pc:  24'h000000,
    rst_valid: 1'b0,
    rst_pc:   24'h000000,
    waitreq:  1'b1,
    rdata:    32'h00000000,
    cpu_en:   1'b1,
    per_en:   1'b1,
    osc_en:   1'b1,
    fscm_en:  1'b1,
    low_power_rc_clock_en:  1'b1,
    lv_event: 1'b0,
    osc_sel:  2'h0
  };

  state_t s_reg;
  state_t s_next;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // true when the source needs start-up timer and lock on wake
  function automatic logic slow_start(input logic [1:0] fam,
                                      input logic [3:0] pmode,
                                      input logic       lp_keep);
    slow_start = (fam == rst_pwr_pkg::OSC_FAM_PRI &&
                  !pmode[rst_pwr_pkg::OSC_EXT_BIT]) ||
                 (fam == rst_pwr_pkg::OSC_FAM_LP && !lp_keep);
  endfunction : slow_start

  function automatic logic [31:0] read_word(input state_t    s,
                                            input logic [3:0] a);
    read_word = 32'h00000000;
    if (a == rst_pwr_pkg::CTRL_OFF) begin
      read_word = {16'h0000, s.ctl};
    end else if (a == rst_pwr_pkg::WDT_OFF) begin
      read_word = {16'h0000, s.wdt_cnt};
    end
  endfunction : read_word

  logic wdt_on;
  logic wdt_ovf;
  logic asleep;
  logic idle;
  logic [15:0] wmask;

  assign wdt_on = watchdog_fuse_enable |
                  s_reg.ctl[rst_pwr_pkg::DOG_SW_EN_BIT];
  assign wdt_ovf = wdt_on && s_reg.low_power_rc_clock_en && low_power_rc_clock_tick &&
                   !watchdog_clear_instr &&
                   s_reg.wdt_cnt == WDT_TERMINAL;
  assign asleep = s_reg.mode == rst_pwr_pkg::PM_SLEEP;
  assign idle   = s_reg.mode == rst_pwr_pkg::PM_IDLE;
  assign wmask  = rst_pwr_pkg::CTRL_WR_MASK &
                  {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic        go_now;
    logic        go_wait;
    logic        use_fuse;
    logic [23:0] tgt;
    logic [1:0]  sel;
    logic        slow;
    logic        lp_hold;
    go_now   = 1'b0;
    go_wait  = 1'b0;
    use_fuse = 1'b0;
    tgt      = rst_pwr_pkg::RESET_VECTOR;
    sel      = 2'h0;
    slow     = 1'b0;
    lp_hold  = 1'b0;
    s_next = s_reg;
    s_next.rst_valid = 1'b0;

    // bus slave: one wait cycle, then a single ready cycle
    if (!s_reg.waitreq) begin
      s_next.waitreq = 1'b1;
      if (avs_write && avs_address == rst_pwr_pkg::CTRL_OFF) begin
        s_next.ctl = (s_reg.ctl & ~wmask) |
                     (avs_writedata[15:0] & wmask);
      end
    end else if (avs_read || avs_write) begin
      s_next.waitreq = 1'b0;
      s_next.rdata   = read_word(s_reg, avs_address);
    end

    // watchdog count on RC ticks
    if (watchdog_clear_instr || !wdt_on) begin
      s_next.wdt_cnt = 16'h0000;
    end else if (low_power_rc_clock_tick && s_reg.low_power_rc_clock_en) begin
      s_next.wdt_cnt = wdt_ovf ? 16'h0000 :
                       s_reg.wdt_cnt + 16'h0001;
    end

    // events, highest priority first; hardware wins over a write
    if (por_event) begin
      s_next.ctl = 16'h0000;
      s_next.ctl[rst_pwr_pkg::POR_BIT] = 1'b1;
      s_next.ctl[rst_pwr_pkg::BOR_BIT] = 1'b1;
      use_fuse = 1'b1;
      go_wait  = 1'b1;
    end else if (brown_out_reset) begin
      s_next.ctl[rst_pwr_pkg::BOR_BIT] = 1'b1;
      s_next.ctl[rst_pwr_pkg::POR_BIT] = 1'b0;
      use_fuse = 1'b1;
      go_wait  = 1'b1;
    end else if (external_reset_pin) begin
      s_next.ctl[rst_pwr_pkg::PIN_RST_BIT] = 1'b1;
      s_next.ctl[rst_pwr_pkg::DOG_TMO_BIT] = 1'b0;
      s_next.ctl[rst_pwr_pkg::SLEEP_BIT] = asleep;
      s_next.ctl[rst_pwr_pkg::IDLE_BIT]  = idle;
      if (!asleep && !idle) begin
        s_next.ctl[rst_pwr_pkg::SOFT_RST_BIT] = 1'b0;
      end
      go_wait = asleep;
      go_now  = !asleep;
    end else if (trap_conflict_event) begin
      s_next.ctl[rst_pwr_pkg::TRAP_BIT] = 1'b1;
      go_now = 1'b1;
    end else if (illegal_op_event) begin
      s_next.ctl[rst_pwr_pkg::ILLOP_BIT] = 1'b1;
      go_now = 1'b1;
    end else if (soft_reset_event) begin
      s_next.ctl[rst_pwr_pkg::SOFT_RST_BIT] = 1'b1;
      s_next.ctl[rst_pwr_pkg::PIN_RST_BIT]  = 1'b0;
      s_next.ctl[rst_pwr_pkg::DOG_TMO_BIT]  = 1'b0;
      s_next.ctl[rst_pwr_pkg::IDLE_BIT]  = 1'b0;
      s_next.ctl[rst_pwr_pkg::SLEEP_BIT] = 1'b0;
      go_now = 1'b1;
    end else if (wdt_ovf) begin
      s_next.ctl[rst_pwr_pkg::DOG_TMO_BIT] = 1'b1;
      if (asleep || idle) begin
        // wake only adds its own mode flag; the other one is kept
        s_next.ctl[rst_pwr_pkg::SLEEP_BIT] |= asleep;
        s_next.ctl[rst_pwr_pkg::IDLE_BIT]  |= idle;
        tgt     = pc_current + rst_pwr_pkg::PC_STEP;
        go_wait = asleep;
        go_now  = idle;
      end else begin
        s_next.ctl[rst_pwr_pkg::PIN_RST_BIT]  = 1'b0;
        s_next.ctl[rst_pwr_pkg::SOFT_RST_BIT] = 1'b0;
        s_next.ctl[rst_pwr_pkg::IDLE_BIT]  = 1'b0;
        s_next.ctl[rst_pwr_pkg::SLEEP_BIT] = 1'b0;
        go_now = 1'b1;
      end
    end else if (clock_fail_event && !asleep) begin
      tgt    = rst_pwr_pkg::CLKFAIL_VECTOR;
      go_now = 1'b1;
    end else if (irq_wake && (asleep || idle)) begin
      if (asleep) begin
        s_next.ctl[rst_pwr_pkg::SLEEP_BIT] = 1'b1;
      end else begin
        s_next.ctl[rst_pwr_pkg::IDLE_BIT] = 1'b1;
      end
      tgt     = irq_vector;
      go_wait = asleep;
      go_now  = idle;
    end else if (power_save_instr &&
                 s_reg.mode == rst_pwr_pkg::PM_RUN) begin
      s_next.mode = power_save_sleep ? rst_pwr_pkg::PM_SLEEP :
                    rst_pwr_pkg::PM_IDLE;
    end

    // wake clock choice and start-up delay
    sel = (use_fuse || !clock_switch_enable) ? osc_family_fuse :
          current_osc_select;
    slow = slow_start(sel, primary_osc_mode_fuse, lp_keep_in_sleep);
    if (go_wait) begin
      s_next.mode    = rst_pwr_pkg::PM_WAKE;
      s_next.pend_pc = tgt;
      s_next.osc_sel = sel;
      s_next.need_osc = slow;
      s_next.delay   = slow ?
        32'(rst_pwr_pkg::PWR_ON_CYCLES) + 32'(PWRT_CYCLES) :
        32'(rst_pwr_pkg::PWR_ON_CYCLES);
    end else if (go_now) begin
      s_next.mode      = rst_pwr_pkg::PM_RUN;
      s_next.rst_valid = 1'b1;
      s_next.rst_pc    = tgt;
    end else if (s_reg.mode == rst_pwr_pkg::PM_WAKE) begin
      if (s_reg.delay != 32'h00000000) begin
        s_next.delay = s_reg.delay - 32'h00000001;
      end else if (!s_reg.need_osc ||
                   (osc_startup_done &&
                    (!pll_used || pll_lock))) begin
        s_next.mode      = rst_pwr_pkg::PM_RUN;
        s_next.rst_valid = 1'b1;
        s_next.rst_pc    = s_reg.pend_pc;
      end
    end

    // clock gating follows the next mode
    lp_hold = s_reg.osc_sel == rst_pwr_pkg::OSC_FAM_LP &&
              lp_keep_in_sleep;
    s_next.cpu_en  = s_next.mode == rst_pwr_pkg::PM_RUN;
    s_next.per_en  = s_next.mode == rst_pwr_pkg::PM_RUN ||
                     s_next.mode == rst_pwr_pkg::PM_IDLE;
    s_next.fscm_en = s_next.per_en;
    s_next.osc_en  = s_next.mode != rst_pwr_pkg::PM_SLEEP || lp_hold;
    s_next.low_power_rc_clock_en = s_next.mode != rst_pwr_pkg::PM_SLEEP ||
                     wdt_on;

    // low-voltage detector and reference status
    s_next.ctl[rst_pwr_pkg::REFOK_BIT] =
      s_next.ctl[rst_pwr_pkg::LV_EN_BIT] & reference_ready;
    s_next.lv_event =
      s_next.ctl[rst_pwr_pkg::LV_EN_BIT] & voltage_below;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= RESET_STATE;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign avs_readdata        = s_reg.rdata;
  assign avs_waitrequest     = s_reg.waitreq;
  assign restart_valid       = s_reg.rst_valid;
  assign restart_pc          = s_reg.rst_pc;
  assign cpu_clock_enable    = s_reg.cpu_en;
  assign periph_clock_enable = s_reg.per_en;
  assign osc_run             = s_reg.osc_en;
  assign fscm_enable         = s_reg.fscm_en;
  assign low_power_rc_clock_run            = s_reg.low_power_rc_clock_en;
  assign lvd_enable          = s_reg.ctl[rst_pwr_pkg::LV_EN_BIT];
  assign low_voltage_threshold =
    s_reg.ctl[rst_pwr_pkg::LV_THR_LSB +: 4];
  assign low_voltage_event   = s_reg.lv_event;
  assign wake_osc            = s_reg.osc_sel;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking dc @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (reset);

  sequence pin_run_s;
    external_reset_pin && !por_event && !brown_out_reset &&
    s_reg.mode == rst_pwr_pkg::PM_RUN;
  endsequence
  sequence wdt_sleep_s;
    wdt_ovf && asleep && !por_event && !brown_out_reset &&
    !external_reset_pin && !trap_conflict_event &&
    !illegal_op_event && !soft_reset_event;
  endsequence

  por_flags_a: assert property (por_event |=>
    s_reg.ctl[15:0] == 16'h0003 &&
    s_reg.mode == rst_pwr_pkg::PM_WAKE)
    else $error("power-on flags wrong");
  bor_flags_a: assert property (brown_out_reset && !por_event |=>
    s_reg.ctl[1:0] == 2'b10 &&
    s_reg.ctl[15:14] == $past(s_reg.ctl[15:14]))
    else $error("brown-out flags wrong");
  pin_run_a: assert property (pin_run_s |=>
    s_reg.ctl[7:6] == 2'b10 && s_reg.ctl[4:2] == 3'b000 &&
    restart_valid && restart_pc == 24'h000000)
    else $error("pin reset flags wrong");
  soft_rst_a: assert property (soft_reset_event && !por_event &&
    !brown_out_reset && !external_reset_pin &&
    !trap_conflict_event && !illegal_op_event |=>
    s_reg.ctl[7:6] == 2'b01 && s_reg.ctl[4:2] == 3'b000 &&
    restart_valid)
    else $error("soft reset flags wrong");
  pin_sleep_a: assert property (external_reset_pin && asleep &&
    !por_event && !brown_out_reset |=>
    s_reg.ctl[7] && s_reg.ctl[4:2] == 3'b010 &&
    s_reg.mode == rst_pwr_pkg::PM_WAKE)
    else $error("pin reset in sleep wrong");
  wdt_wake_a: assert property (wdt_sleep_s |=>
    s_reg.ctl[4:3] == 2'b11 &&
    s_reg.pend_pc == $past(pc_current) + 24'h000002)
    else $error("watchdog wake wrong");
  clk_fail_a: assert property (clock_fail_event && !asleep &&
    !por_event && !brown_out_reset && !external_reset_pin &&
    !trap_conflict_event && !illegal_op_event &&
    !soft_reset_event && !wdt_ovf |=>
    restart_valid && restart_pc == 24'h000004 &&
    s_reg.ctl[7:0] == $past(s_reg.ctl[7:0]))
    else $error("clock failure vector wrong");
  sleep_gate_a: assert property (asleep |->
    !cpu_clock_enable && !periph_clock_enable && !fscm_enable &&
    low_power_rc_clock_run == wdt_on)
    else $error("sleep gating wrong");
  bus_ready_a: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
endmodule : reset_status_watchdog_sleep
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the reset, watchdog and power-save block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin checks++; if ((got) !== (want)) begin \
  num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, want); \
  end end
module tb_top;
  localparam logic [15:0] WT     = 16'h0004;
  localparam logic [15:0] F_PIN  = 16'h0080;
  localparam logic [15:0] F_SOFT = 16'h0040;
  localparam logic [15:0] F_WDOG = 16'h0010;
  localparam logic [15:0] F_SLP  = 16'h0008;
  localparam logic [15:0] F_IDL  = 16'h0004;
  localparam logic [15:0] F_MODE = 16'h00dc;
  logic        clk_sys, reset, clk_en, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable, primary_osc_mode_fuse;
  logic [31:0] avs_writedata, avs_readdata, seed, v;
  logic [7:0]  ev;
  logic [23:0] irq_vector, pc_current, restart_pc;
  logic        power_save_instr, power_save_sleep, watchdog_clear_instr;
  logic        low_power_rc_clock_tick, watchdog_fuse_enable, clock_switch_enable;
  logic        lp_keep_in_sleep, pll_used, pll_lock, osc_startup_done;
  logic        reference_ready, voltage_below, restart_valid;
  logic        cpu_clock_enable, periph_clock_enable, osc_run, fscm_enable;
  logic        low_power_rc_clock_run, lvd_enable, low_voltage_event;
  logic [1:0]  osc_family_fuse, current_osc_select, wake_osc;
  logic [3:0]  low_voltage_threshold;
  logic [15:0] flg;
  logic [31:0] exp_rd[$];
  logic [23:0] exp_pc[$];
  logic [31:0] er;
  logic [23:0] ep;
  int          num_errors, checks, n_rst, cyc;

  reset_status_watchdog_sleep #(.WDT_TERMINAL(WT), .PWRT_CYCLES(10)) dut (
    .clk_sys, .reset, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .por_event(ev[0]), .brown_out_reset(ev[1]), .external_reset_pin(ev[2]),
    .trap_conflict_event(ev[3]), .illegal_op_event(ev[4]),
    .soft_reset_event(ev[5]), .clock_fail_event(ev[6]), .irq_wake(ev[7]),
    .irq_vector, .pc_current, .power_save_instr, .power_save_sleep,
    .watchdog_clear_instr, .low_power_rc_clock_tick, .watchdog_fuse_enable,
    .osc_family_fuse, .primary_osc_mode_fuse, .current_osc_select,
    .clock_switch_enable, .lp_keep_in_sleep, .pll_used, .pll_lock,
    .osc_startup_done, .reference_ready, .voltage_below, .restart_valid,
    .restart_pc, .cpu_clock_enable, .periph_clock_enable, .osc_run,
    .fscm_enable, .low_power_rc_clock_run, .lvd_enable, .low_voltage_threshold,
    .low_voltage_event, .wake_osc
  );

  // ---------------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs();
    logic [31:0] s;
    s = seed;
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    seed = s;
    return s;
  endfunction : xs

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [15:0] d);
    @(posedge clk_sys);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rd

  task automatic wr(input logic [15:0] d);
    bus(1'b1, rst_pwr_pkg::CTRL_OFF, d);
    flg = (flg & ~rst_pwr_pkg::CTRL_WR_MASK) | (d & rst_pwr_pkg::CTRL_WR_MASK);
    flg[13] = flg[12] & reference_ready;
  endtask : wr

  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev <= 8'h01 << i;
    @(posedge clk_sys);
    ev <= 8'h00;
  endtask : pulse

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      low_power_rc_clock_tick <= 1'b1;
      @(posedge clk_sys);
      low_power_rc_clock_tick <= 1'b0;
    end
  endtask : ticks

  task automatic nap(input logic sl);
    @(posedge clk_sys);
    power_save_instr <= 1'b1;
    power_save_sleep <= sl;
    @(posedge clk_sys);
    power_save_instr <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : nap

  // event i (or watchdog overflow when i < 0), expected flags and restart
  task automatic fire(input int i, input logic [15:0] s, input logic [15:0] c,
                      input logic [23:0] pc, input logic slow);
    int n0;
    int k;
    n0 = n_rst;
    k = 0;
    exp_pc.push_back(pc);
    flg = (flg & ~c) | s;
    if (i >= 0) pulse(i);
    else ticks(int'(WT) + 1);
    if (slow) begin
      repeat (2200) @(posedge clk_sys);
      `CHK(n_rst, n0)
      osc_startup_done <= 1'b1;
      repeat (50) @(posedge clk_sys);
      `CHK(n_rst, n0)
      pll_lock <= 1'b1;
    end
    while (n_rst == n0) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(k <= rst_pwr_pkg::PWR_ON_CYCLES + 8, 1'b1)
    rd(rst_pwr_pkg::CTRL_OFF, {16'h0000, flg});
  endtask : fire

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------------
  // clock, timeout and output monitor
  // ---------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      give_verdict();
    end
  end

  always @(posedge clk_sys) begin
    if (avs_waitrequest === 1'b0 && avs_read === 1'b1) begin
      er = exp_rd.size() ? exp_rd.pop_front() : 'x;
      `CHK(avs_readdata, er)
    end
    if (restart_valid === 1'b1) begin
      ep = exp_pc.size() ? exp_pc.pop_front() : 'x;
      `CHK(restart_pc, ep)
      n_rst++;
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata, ev} = '0;
    {irq_vector, pc_current, power_save_instr, power_save_sleep} = '0;
    {watchdog_clear_instr, low_power_rc_clock_tick, watchdog_fuse_enable} = '0;
    {pll_used, pll_lock, osc_startup_done, voltage_below} = '0;
    {num_errors, checks, n_rst, cyc} = '0;
    clk_en = 1'b1;
    avs_byteenable = 4'hf;
    lp_keep_in_sleep = 1'b0;
    clock_switch_enable = 1'b1;
    primary_osc_mode_fuse = 4'h0;
    reference_ready = 1'b0;
    osc_family_fuse = rst_pwr_pkg::OSC_FAM_FRC;
    current_osc_select = rst_pwr_pkg::OSC_FAM_LOW_POWER_RC_CLOCK;
    seed = 32'hc4cb;
    reset = 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    flg = rst_pwr_pkg::CTRL_RESET;
    rd(rst_pwr_pkg::CTRL_OFF, 32'h0000_0003);
    rd(4'h8, 32'h0000_0000);
    rd(rst_pwr_pkg::WDT_OFF, 32'h0000_0000);
    v = xs();
    wr({4'h1, v[3:0], 8'h00});
    rd(rst_pwr_pkg::CTRL_OFF, {16'h0000, flg});
    reference_ready <= 1'b1;
    voltage_below <= 1'b1;
    flg[13] = 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(rst_pwr_pkg::CTRL_OFF, {16'h0000, flg});
    `CHK(lvd_enable, 1'b1)
    `CHK(low_voltage_threshold, v[3:0])
    `CHK(low_voltage_event, 1'b1)
    wr(16'hffff);
    rd(rst_pwr_pkg::CTRL_OFF, {16'h0000, flg});
    wr(16'h0000);
    repeat (3) @(posedge clk_sys);
    `CHK(low_voltage_event, 1'b0)
    fire(5, F_SOFT, F_PIN | F_WDOG | F_IDL | F_SLP, 24'h0, 1'b0);
    fire(2, F_PIN, F_SOFT | F_WDOG | F_IDL | F_SLP, 24'h0, 1'b0);
    fire(3, 16'h8000, 16'h0000, 24'h0, 1'b0);
    fire(4, 16'h4000, 16'h0000, 24'h0, 1'b0);
    fire(6, 16'h0000, 16'h0000, 24'h4, 1'b0);
    fire(1, 16'h0002, 16'h0001, 24'h0, 1'b0);
    `CHK(wake_osc, rst_pwr_pkg::OSC_FAM_FRC)
    osc_family_fuse <= rst_pwr_pkg::OSC_FAM_LP;
    lp_keep_in_sleep <= 1'b1;
    fire(0, 16'h0003, 16'hffff, 24'h0, 1'b0);
    lp_keep_in_sleep <= 1'b0;
    `CHK(wake_osc, rst_pwr_pkg::OSC_FAM_LP)
    nap(1'b1);
    `CHK({cpu_clock_enable, periph_clock_enable, osc_run}, 3'b000)
    `CHK({fscm_enable, low_power_rc_clock_run}, 2'b00)
    v = xs();
    irq_vector <= v[23:0];
    fire(7, F_SLP, 16'h0000, v[23:0], 1'b0);
    `CHK(wake_osc, rst_pwr_pkg::OSC_FAM_LOW_POWER_RC_CLOCK)
    `CHK(cpu_clock_enable, 1'b1)
    nap(1'b1);
    fire(2, F_PIN | F_SLP, F_WDOG | F_IDL, 24'h0, 1'b0);
    nap(1'b0);
    fire(2, F_PIN | F_IDL, F_WDOG | F_SLP, 24'h0, 1'b0);
    wr(16'h0020);
    ticks(int'(WT));
    rd(rst_pwr_pkg::WDT_OFF, {16'h0000, WT});
    @(posedge clk_sys);
    watchdog_clear_instr <= 1'b1;
    @(posedge clk_sys);
    watchdog_clear_instr <= 1'b0;
    rd(rst_pwr_pkg::WDT_OFF, 32'h0000_0000);
    fire(-1, F_WDOG, F_PIN | F_SOFT | F_IDL | F_SLP, 24'h0, 1'b0);
    wr(16'h0000);
    watchdog_fuse_enable <= 1'b1;
    v = xs();
    pc_current <= v[23:0];
    nap(1'b1);
    `CHK(low_power_rc_clock_run, 1'b1)
    fire(-1, F_WDOG | F_SLP, 16'h0000, v[23:0] + 24'h2, 1'b0);
    watchdog_fuse_enable <= 1'b0;
    current_osc_select <= rst_pwr_pkg::OSC_FAM_PRI;
    pll_used <= 1'b1;
    nap(1'b1);
    v = xs();
    irq_vector <= v[23:0];
    fire(7, F_SLP, 16'h0000, v[23:0], 1'b1);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
